// ==== bench/ccr_host_model.sv ====
`timescale 1ns/1ps
module ccr_host_model (
  input  wire        sys_clk_in,
  input  wire [15:0] reg_rdata_out,
  input  wire        reg_rvalid_out,
  input  wire        reg_hit_out,
  input  wire        reg_wr_refused_out,
  output reg  [3:0]  reg_addr_in = 4'h0,
  output reg         reg_rd_in = 1'b0,
  output reg         reg_wr_in = 1'b0
);
  task acc(input w, input [3:0] a, output [18:0] q);
    @(posedge sys_clk_in) #1;
    {reg_wr_in, reg_rd_in, reg_addr_in} = {w, !w, a};
    @(posedge sys_clk_in) #1;
    {reg_wr_in, reg_rd_in, reg_addr_in} = {2'h0, ~a};
    q = {reg_rdata_out, reg_rvalid_out, reg_hit_out, reg_wr_refused_out};
  endtask
endmodule // ccr_host_model

// ==== bench/ccr_result_regs_sva.sv ====
`timescale 1ns/1ps
module ccr_result_regs_sva (
  input wire        sys_clk_in,
  input wire        srst_in,
  input wire [3:0]  reg_addr_in,
  input wire        reg_rd_in,
  input wire        reg_wr_in,
  input wire [15:0] reg_rdata_out,
  input wire        reg_rvalid_out,
  input wire        reg_hit_out,
  input wire        reg_wr_refused_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  // strobe aimed at the result words 4h..7h
  wire map = reg_addr_in[3:2] == 2'h1;
  property p_rv; reg_rd_in |=> reg_rvalid_out; endproperty
  property p_norv; !reg_rd_in |=> !reg_rvalid_out; endproperty
  property p_hit; reg_rd_in |=> reg_hit_out == $past(map); endproperty
  property p_unm; reg_rd_in && !map |=> reg_rdata_out == 16'h0; endproperty
  property p_ref; reg_wr_in && map |=> reg_wr_refused_out; endproperty
  property p_noref; !(reg_wr_in && map) |=> !reg_wr_refused_out; endproperty
  property p_hold; !reg_rd_in |=> $stable(reg_rdata_out); endproperty
  property p_rst; $fell(srst_in) |-> reg_rdata_out == 16'h0; endproperty
  a_rv: assert property (p_rv) else $error("no rvalid");
  a_norv: assert property (p_norv) else $error("stray rvalid");
  a_hit: assert property (p_hit) else $error("hit wrong");
  a_unm: assert property (p_unm) else $error("unmapped data");
  a_ref: assert property (p_ref) else $error("no refusal");
  a_noref: assert property (p_noref) else $error("stray refusal");
  a_hold: assert property (p_hold) else $error("rdata moved");
  a_rst: assert property (p_rst) else $error("rdata after reset");
endmodule // ccr_result_regs_sva
bind ccr_result_regs ccr_result_regs_sva chk (.*);

// ==== bench/test_color_channel_result_regs.sv ====
`timescale 1ns/1ps
module test_color_channel_result_regs;
  reg         sys_clk_in = 1'b0, srst_in = 1'b1;
  reg  [1:0]  done = 2'h0;
  reg  [3:0]  rng = 4'h0;
  reg  [19:0] res = 20'h0;
  reg  [18:0] q;
  wire [3:0]  reg_addr_in;
  wire [15:0] reg_rdata_out;
  wire reg_rd_in, reg_wr_in, reg_rvalid_out, reg_hit_out, reg_wr_refused_out;
  integer     fails = 0, total_checks = 0, i;
  // 20 MHz clock
  always #25 sys_clk_in = ~sys_clk_in;
  ccr_result_regs uut (.*, .ch2_done_in(done[0]), .ch3_done_in(done[1]),
    .ch2_range_in(rng), .ch3_range_in(rng), .ch2_result_in(res),
    .ch3_result_in(res));
  ccr_host_model host (.*);
  task chk(input string n, input [15:0] e, input [15:0] g);
    total_checks = total_checks + 1;
    fails = fails + (g !== e);
    if (g !== e) $display("BAD %s exp %h got %h", n, e, g);
  endtask
  function [15:0] lo(input [3:0] e, input [19:0] r, input [3:0] c);
    lo = {r[7:0], c, r[3] ^ r[11] ^ r[19], c[3] ^ e[3] ^ (^(r & 20'h88888)),
      c[1] ^ c[3] ^ e[1] ^ e[3] ^ (^(r & 20'haaaaa)), ^{e, r, c}};
  endfunction
  task conv(input [1:0] m, input [3:0] e, input [19:0] r);
    @(posedge sys_clk_in) #1;
    {done, rng, res} = {m, e, r};
    @(posedge sys_clk_in) #1;
    {done, rng, res} = {2'h0, ~e, ~r};
  endtask
  task rd(input [3:0] a, input [15:0] e);
    host.acc(1'b0, a, q);
    chk("rdata", e, q[18:3]);
    chk("flags", {13'h0, 1'b1, a[3:2] == 2'h1, 1'b0}, {13'h0, q[2:0]});
  endtask
  task t_reset;
    for (i = 3; i < 10; i = i + 1)
      rd(i[3:0], 16'h0);
    $display("reset test done");
  endtask
  task t_fields;
    conv(2'h1, 4'ha, 20'h12345);
    rd(4'h4, 16'ha123);
    conv(2'h1, 4'h5, 20'habcde);
    rd(4'h5, lo(4'ha, 20'h12345, 4'h1));
    rd(4'h5, lo(4'h5, 20'habcde, 4'h2));
    conv(2'h2, 4'h3, 20'hf0f0f);
    rd(4'h6, 16'h3f0f);
    rd(4'h7, lo(4'h3, 20'hf0f0f, 4'h1));
    repeat (16) conv(2'h3, 4'h7, 20'h00080);
    rd(4'h7, lo(4'h7, 20'h00080, 4'h1));
    rd(4'h5, lo(4'h7, 20'h00080, 4'h2));
    $display("field test done");
  endtask
  task t_write;
    host.acc(1'b1, 4'h4, q);
    chk("refused", 16'h1, {15'h0, q[0]});
    rd(4'h4, 16'h7000);
    host.acc(1'b1, 4'h8, q);
    chk("refused", 16'h0, {15'h0, q[0]});
    $display("write test done");
  endtask
  // reset in mid-run clears stored fields and counts
  task t_midrst;
    @(posedge sys_clk_in) #1;
    srst_in = 1'b1;
    repeat (2) @(posedge sys_clk_in);
    #1 srst_in = 1'b0;
    rd(4'h4, 16'h0);
    rd(4'h5, 16'h0);
    rd(4'h6, 16'h0);
    rd(4'h7, 16'h0);
    $display("mid-run reset test done");
  endtask
  task stop_test;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // reset for 5 cycles, then the scenarios
  initial
  begin
    repeat (5) @(posedge sys_clk_in);
    #1 srst_in = 1'b0;
    t_reset;
    t_fields;
    t_write;
    t_midrst;
    stop_test;
  end
endmodule // test_color_channel_result_regs

// ==== verilog/ccr_check_code.v ====
`timescale 1ns/1ps
// check code over range code, 20-bit result and sample count
module ccr_check_code (
  input  wire [3:0]  range_in,
  input  wire [19:0] result_in,
  input  wire [3:0]  count_in,
  output wire [3:0]  check_out
);
  // odd result bits and the every-fourth-bit subset
  wire odd_r  = ^{result_in[19], result_in[17], result_in[15], result_in[13],
                  result_in[11], result_in[9], result_in[7], result_in[5],
                  result_in[3], result_in[1]};
  wire quad_r = ^{result_in[19], result_in[15], result_in[11],
                  result_in[7], result_in[3]};

  // parity terms
  assign check_out[0] = ^{range_in, result_in, count_in};
  assign check_out[1] = count_in[1] ^ count_in[3] ^ odd_r ^
                        range_in[1] ^ range_in[3];
  assign check_out[2] = count_in[3] ^ quad_r ^ range_in[3];
  assign check_out[3] = result_in[3] ^ result_in[11] ^
                        result_in[19];
endmodule // ccr_check_code

// ==== verilog/ccr_consts.vh ====
// Contract
// - chan2 range code in word 4h bits 15-12
// - chan2 upper 12 result bits in 4h[11:0]
// - chan3 same layout at word 6h
// - chan2 lower 8 result bits in 5h[15:8]
// - chan3 lower 8 result bits in 7h[15:8]
// - 4-bit wrapping count per conversion, bits 7-4
// - check bit 0 is parity over everything
// - check bits 1-3 from partial XOR terms
`ifndef CCR_CONSTS_VH
`define CCR_CONSTS_VH

// register word offsets
`define CCR_OFS_CH2_HI    4'h4
`define CCR_OFS_CH2_LO    4'h5
`define CCR_OFS_CH3_HI    4'h6
`define CCR_OFS_CH3_LO    4'h7

// field positions, upper word
`define CCR_RANGE_MSB     15
`define CCR_RANGE_LSB     12
`define CCR_UPPER_MSB     11
`define CCR_UPPER_LSB     0

// field positions, lower word
`define CCR_LOWER_MSB     15
`define CCR_LOWER_LSB     8
`define CCR_COUNT_MSB     7
`define CCR_COUNT_LSB     4
`define CCR_CHECK_MSB     3
`define CCR_CHECK_LSB     0

// widths and reset values
`define CCR_WORD_W        16
`define CCR_ADDR_W        4
`define CCR_RESULT_W      20
`define CCR_RST_WORD      16'h0000
`define CCR_RST_NIB       4'h0
`define CCR_RST_RESULT    20'h00000
`define CCR_COUNT_STEP    4'h1

`endif

// ==== verilog/ccr_result_regs.v ====
`timescale 1ns/1ps
`include "ccr_consts.vh"
// result words for channels 2 and 3 with a host register read port
module ccr_result_regs (
  input  wire        sys_clk_in,
  input  wire        srst_in,
  // conversion results, channel 2
  input  wire        ch2_done_in,
  input  wire [3:0]  ch2_range_in,
  input  wire [19:0] ch2_result_in,
  // conversion results, channel 3
  input  wire        ch3_done_in,
  input  wire [3:0]  ch3_range_in,
  input  wire [19:0] ch3_result_in,
  // host register port
  input  wire [3:0]  reg_addr_in,
  input  wire        reg_rd_in,
  input  wire        reg_wr_in,
  output reg  [15:0] reg_rdata_out,
  output reg         reg_rvalid_out,
  output reg         reg_hit_out,
  output reg         reg_wr_refused_out
);
  // stored fields per channel
  reg  [3:0]  chan2_range_code;
  reg  [11:0] chan2_result_upper;
  reg  [7:0]  chan2_result_lower;
  reg  [3:0]  chan2_sample_count;
  reg  [3:0]  chan2_check_code;
  reg  [3:0]  chan3_range_code;
  reg  [11:0] chan3_result_upper;
  reg  [7:0]  chan3_result_lower;
  reg  [3:0]  chan3_sample_count;
  reg  [3:0]  chan3_check_code;

  // lower-word snapshots taken when the upper word is read
  reg  [15:0] chan2_lo_shadow;
  reg         chan2_shadow_valid;
  reg  [15:0] chan3_lo_shadow;
  reg         chan3_shadow_valid;

  wire [3:0]  next_chan2_count;
  wire [3:0]  next_chan3_count;
  wire [3:0]  next_chan2_check;
  wire [3:0]  next_chan3_check;
  wire [15:0] chan2_hi_word;
  wire [15:0] chan2_lo_word;
  wire [15:0] chan3_hi_word;
  wire [15:0] chan3_lo_word;
  reg  [15:0] next_rdata;
  reg         next_hit;
  wire        ro_target;

  // counts advance by one per conversion and wrap at 4 bits
  assign next_chan2_count = chan2_sample_count + `CCR_COUNT_STEP;
  assign next_chan3_count = chan3_sample_count + `CCR_COUNT_STEP;

  // check codes are built from the values about to be stored
  ccr_check_code u_chan2_check (
    .range_in  (ch2_range_in),
    .result_in (ch2_result_in),
    .count_in  (next_chan2_count),
    .check_out (next_chan2_check)
  );

  ccr_check_code u_chan3_check (
    .range_in  (ch3_range_in),
    .result_in (ch3_result_in),
    .count_in  (next_chan3_count),
    .check_out (next_chan3_check)
  );

  // channel 2 capture on completed conversion
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      chan2_range_code   <= `CCR_RST_NIB;
      chan2_result_upper <= 12'h000;
      chan2_result_lower <= 8'h00;
      chan2_sample_count <= `CCR_RST_NIB;
      chan2_check_code   <= `CCR_RST_NIB;
    end
    else if (ch2_done_in)
    begin
      chan2_range_code   <= ch2_range_in;
      chan2_result_upper <= ch2_result_in[19:8];
      chan2_result_lower <= ch2_result_in[7:0];
      chan2_sample_count <= next_chan2_count;
      chan2_check_code   <= next_chan2_check;
    end
  end

  // channel 3 capture on completed conversion
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      chan3_range_code   <= `CCR_RST_NIB;
      chan3_result_upper <= 12'h000;
      chan3_result_lower <= 8'h00;
      chan3_sample_count <= `CCR_RST_NIB;
      chan3_check_code   <= `CCR_RST_NIB;
    end
    else if (ch3_done_in)
    begin
      chan3_range_code   <= ch3_range_in;
      chan3_result_upper <= ch3_result_in[19:8];
      chan3_result_lower <= ch3_result_in[7:0];
      chan3_sample_count <= next_chan3_count;
      chan3_check_code   <= next_chan3_check;
    end
  end

  // word assembly
  assign chan2_hi_word = {chan2_range_code, chan2_result_upper};
  assign chan3_hi_word = {chan3_range_code, chan3_result_upper};
  assign chan2_lo_word = {chan2_result_lower, chan2_sample_count,
                          chan2_check_code};
  assign chan3_lo_word = {chan3_result_lower, chan3_sample_count,
                          chan3_check_code};

  // snapshot keeps an upper/lower read pair from one conversion
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      chan2_lo_shadow    <= `CCR_RST_WORD;
      chan2_shadow_valid <= 1'b0;
      chan3_lo_shadow    <= `CCR_RST_WORD;
      chan3_shadow_valid <= 1'b0;
    end
    else if (reg_rd_in)
    begin
      if (reg_addr_in == `CCR_OFS_CH2_HI)
      begin
        chan2_lo_shadow    <= chan2_lo_word;
        chan2_shadow_valid <= 1'b1;
      end
      else if (reg_addr_in == `CCR_OFS_CH2_LO)
        chan2_shadow_valid <= 1'b0;
      if (reg_addr_in == `CCR_OFS_CH3_HI)
      begin
        chan3_lo_shadow    <= chan3_lo_word;
        chan3_shadow_valid <= 1'b1;
      end
      else if (reg_addr_in == `CCR_OFS_CH3_LO)
        chan3_shadow_valid <= 1'b0;
    end
  end

  // read decode; unmapped offsets read as zero
  always @*
  begin
    next_rdata = `CCR_RST_WORD;
    next_hit   = 1'b1;
    case (reg_addr_in)
      `CCR_OFS_CH2_HI: next_rdata = chan2_hi_word;
      `CCR_OFS_CH2_LO: next_rdata = chan2_shadow_valid ? chan2_lo_shadow
                                                        : chan2_lo_word;
      `CCR_OFS_CH3_HI: next_rdata = chan3_hi_word;
      `CCR_OFS_CH3_LO: next_rdata = chan3_shadow_valid ? chan3_lo_shadow
                                                        : chan3_lo_word;
      default:
      begin
        next_rdata = `CCR_RST_WORD;
        next_hit   = 1'b0;
      end
    endcase
  end

  // writes to the result words change nothing and are flagged
  assign ro_target = (reg_addr_in >= `CCR_OFS_CH2_HI) &&
                     (reg_addr_in <= `CCR_OFS_CH3_LO);

  // registered read answer, one cycle after the strobe
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      reg_rdata_out      <= `CCR_RST_WORD;
      reg_rvalid_out     <= 1'b0;
      reg_hit_out        <= 1'b0;
      reg_wr_refused_out <= 1'b0;
    end
    else
    begin
      reg_rvalid_out     <= reg_rd_in;
      reg_wr_refused_out <= reg_wr_in && ro_target;
      if (reg_rd_in)
      begin
        reg_rdata_out <= next_rdata;
        reg_hit_out   <= next_hit;
      end
    end
  end
endmodule // ccr_result_regs
